/* File: core/psc_pkg.sv */
// Shared constants for the process sequence controller: timing, key codes,
// register offsets, field positions and the entry mode encoding.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
`default_nettype none

package psc_pkg;

  // Clock and tick timing, each time kept in its own unit.
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned STANDBY_WARN_MS = 2000;
  localparam logic [6:0]  STANDBY_WARN_TENTHS = 7'(STANDBY_WARN_MS / TICK_MS);

  // Preset store size and widths of the stored fields.
  localparam int unsigned PRESET_SLOTS = 10;
  localparam logic [3:0]  PRESET_LAST  = 4'h9;
  localparam int unsigned TEMP_W       = 10;
  localparam int unsigned TIME_W       = 19;
  localparam int unsigned ELAPSED_W    = 23;
  localparam int unsigned PULSE_W      = 7;
  localparam int unsigned AMPL_W       = 7;
  localparam int unsigned KNOB_W       = 8;
  localparam int unsigned KNOB_FULL    = 255;
  localparam int unsigned PCT_FULL     = 100;
  localparam int unsigned SEC_PER_HOUR = 3600;
  localparam int unsigned SEC_PER_MIN  = 60;
  localparam int unsigned TENTHS_PER_SEC = 10;

  // Key codes from the keypad pins or from the key injection register.
  localparam logic [4:0] KEY_DIGIT_MAX = 5'h09;
  localparam logic [4:0] KEY_START     = 5'h0a;
  localparam logic [4:0] KEY_STOP      = 5'h0b;
  localparam logic [4:0] KEY_CLEAR     = 5'h0c;
  localparam logic [4:0] KEY_ENTER     = 5'h0d;
  localparam logic [4:0] KEY_TIME      = 5'h0e;
  localparam logic [4:0] KEY_TEMP      = 5'h0f;
  localparam logic [4:0] KEY_PULSE     = 5'h10;
  localparam logic [4:0] KEY_SAVE      = 5'h11;
  localparam logic [4:0] KEY_RECALL    = 5'h12;

  // Register byte offsets on the APB port.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_KEY     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_PULSE   = 8'h0c;
  localparam logic [7:0] OFS_TEMP    = 8'h10;
  localparam logic [7:0] OFS_TIME    = 8'h14;
  localparam logic [7:0] OFS_ELAPSED = 8'h18;
  localparam logic [7:0] OFS_ENTRY   = 8'h1c;
  localparam logic [7:0] OFS_VIEW    = 8'h20;

  // Reset value of the temperature enable, and register bit and field positions.
  localparam logic                CTRL_TEMP_EN_RST = 1'b0;
  localparam int unsigned         CTRL_TEMP_EN_BIT = 0;
  localparam int unsigned         STAT_MODE_LSB    = 0;
  localparam int unsigned         STAT_SRC_LSB     = 4;
  localparam int unsigned         STAT_FLAG_LSB    = 8;
  localparam int unsigned         FIELD_HI_LSB     = 16;

  // Entry modes, Gray coded along the usual key walk.
  typedef enum logic [2:0] {
    PSC_MODE_MAIN   = 3'b000,
    PSC_MODE_TIME   = 3'b001,
    PSC_MODE_TEMP   = 3'b011,
    PSC_MODE_PON    = 3'b010,
    PSC_MODE_POFF   = 3'b110,
    PSC_MODE_SAVE   = 3'b111,
    PSC_MODE_RECALL = 3'b101
  } psc_mode_e;

  // Who started the current run.
  typedef enum logic [1:0] {
    PSC_SRC_IDLE = 2'b00,
    PSC_SRC_KEY  = 2'b01,
    PSC_SRC_FOOT = 2'b11
  } psc_src_e;

endpackage

`default_nettype wire

/* File: core/psc_tick.sv */
// Free-running divider that marks every tenth of a second with a pulse.
// Assumes the system clock and synchronous active-low reset of the controller.
`default_nettype none

module psc_tick #(
  parameter int unsigned CYCLES = psc_pkg::TICK_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      tick
);
  import psc_pkg::*;

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;

  // Count cycles and wrap; the pulse lasts one clock.
  always_comb begin
    cnt_next  = (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    tick_next = (cnt_reg == LAST);
  end

  // Registers of the divider.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

`default_nettype wire

/* File: core/psc_controller.sv */
// Front-panel sequencing controller: keypad entry of setup values, presets,
// start/stop of the output, pulse duty cycle, processing time and thermal limit.
// Assumes keypad, footswitch, sensor and knob pins are asynchronous, and an APB master.
//
// Functional notes
// - Amplitude mandatory; time and pulse optional.
// - Amplitude shown as percent of knob range.
// - Start key or footswitch energizes; stop de-energizes.
// - Setup functions accepted in any order.
// - Clear key discards the value being entered.
// - Time key enters hours/minutes/seconds; confirm commits.
// - Temperature function stops output at setpoint.
// - Output resumes when temperature falls below setpoint.
// - Thermal key shows live temperature, takes setpoint.
// - At limit: standby, thermal lamp, touch warning.
// - Pulse on and off each 0.1-9.9 s.
// - Pulse off portion: pulse lamp, output off.
// - Off portion over two seconds warns standby.
// - Pulse entry: on, confirm, off, confirm.
// - Ten slots 0-9; save lamp awaits ID.
// - Save confirm stores settings, lamp off, shows them.
// - Recall lamp, ID selects slot to show/use.
// - Time expiry or stop ends run; untimed runs on.
// - Key run ignores footswitch; foot run ignores stop.
//
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none

module psc_controller #(
  parameter int unsigned TICK_CYCLES = psc_pkg::TICK_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic [7:0]                 paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       key_valid,
  input  wire logic [4:0]                 key_code,
  input  wire logic                       footswitch,
  input  wire logic [psc_pkg::TEMP_W-1:0] temp_sense,
  input  wire logic [psc_pkg::KNOB_W-1:0] ampl_knob,
  output logic                            energize,
  output logic                            led_temp,
  output logic                            led_pulse,
  output logic                            led_save,
  output logic                            led_recall,
  output logic                            warn_touch,
  output logic                            warn_standby
);
  import psc_pkg::*;

  localparam int unsigned SLOT_W = TIME_W + TEMP_W + 1 + 2 * PULSE_W + AMPL_W;

  // Two BCD digits to binary.
  function automatic logic [6:0] bcd2(input logic [7:0] d);
    bcd2 = 7'(d[7:4] * 4'd10) + 7'(d[3:0]);
  endfunction

  // Three BCD digits to binary.
  function automatic logic [TEMP_W-1:0] bcd3(input logic [11:0] d);
    bcd3 = TEMP_W'(d[11:8] * 7'd100) + TEMP_W'(bcd2(d[7:0]));
  endfunction

  // Knob position scaled to a percentage of the full amplitude.
  function automatic logic [AMPL_W-1:0] knob_pct(input logic [KNOB_W-1:0] k);
    knob_pct = AMPL_W'((15'(k) * 15'(PCT_FULL)) / 15'(KNOB_FULL));
  endfunction

  // Pin synchronisers: stage one feeds only stage two.
  logic              kv_s1, kv_s2, kv_prev, ft_s1, ft_s2, ft_prev;
  logic [4:0]        kc_s1, kc_s2;
  logic [TEMP_W-1:0] tp_s1, tp_s2;
  logic [KNOB_W-1:0] kn_s1, kn_s2;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {kv_s1, kv_s2, kv_prev, ft_s1, ft_s2, ft_prev} <= 6'h00;
      kc_s1 <= 5'h00;
      kc_s2 <= 5'h00;
      tp_s1 <= '0;
      tp_s2 <= '0;
      kn_s1 <= '0;
      kn_s2 <= '0;
    end else begin
      kv_s1   <= key_valid;
      kv_s2   <= kv_s1;
      kv_prev <= kv_s2;
      ft_s1   <= footswitch;
      ft_s2   <= ft_s1;
      ft_prev <= ft_s2;
      kc_s1   <= key_code;
      kc_s2   <= kc_s1;
      tp_s1   <= temp_sense;
      tp_s2   <= tp_s1;
      kn_s1   <= ampl_knob;
      kn_s2   <= kn_s1;
    end
  end

  logic tick;

  psc_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // State declarations.
  logic [31:0]        prdata_reg, prdata_next;
  logic               pready_reg, pready_next, pslverr_reg, pslverr_next;
  psc_mode_e          mode_reg, mode_next;
  logic [23:0]        entry_reg, entry_next;
  logic [TIME_W-1:0]  time_reg, time_next;
  logic [TEMP_W-1:0]  tset_reg, tset_next;
  logic               temp_en_reg, temp_en_next;
  logic [PULSE_W-1:0] pon_reg, pon_next, poff_reg, poff_next;
  logic [AMPL_W-1:0]  ampl_reg, ampl_next;
  logic [3:0]         view_reg, view_next;
  logic [SLOT_W-1:0]  slot_mem [PRESET_SLOTS];
  logic [SLOT_W-1:0]  slot_next [PRESET_SLOTS];
  psc_src_e           src_reg, src_next;
  logic [ELAPSED_W-1:0] elapsed_reg, elapsed_next;
  logic [PULSE_W-1:0] pcnt_reg, pcnt_next;
  logic               off_reg, off_next, hot_reg, hot_next;
  logic               en_reg, en_next, wstb_reg, wstb_next;
  logic               lsave_reg, lsave_next, lrec_reg, lrec_next;
  logic               setup, access, wr_key, wr_ctrl, key_hit, digit;
  logic [4:0]         key;
  logic [SLOT_W-1:0]  cur_slot, view_slot;

  // APB slave: pready rises in the first access cycle, so every transfer has
  // no wait state; read data and error are captured during setup.
  always_comb begin
    setup        = psel && !penable;
    access       = psel && penable && pready_reg;
    wr_key       = access && pwrite && (paddr == OFS_KEY);
    wr_ctrl      = access && pwrite && (paddr == OFS_CTRL);
    pready_next  = setup;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        OFS_CTRL:    prdata_next[CTRL_TEMP_EN_BIT] = temp_en_reg;
        OFS_KEY:     prdata_next = 32'h0000_0000;
        OFS_STATUS: begin
          prdata_next[STAT_MODE_LSB +: 3] = mode_reg;
          prdata_next[STAT_SRC_LSB +: 2]  = src_reg;
          prdata_next[STAT_FLAG_LSB +: 7] = {wstb_reg, hot_reg, lrec_reg, lsave_reg,
                                             off_reg, hot_reg, en_reg};
        end
        OFS_PULSE:   prdata_next = {1'b0, ampl_reg, 1'b0, poff_reg, 9'h000, pon_reg};
        OFS_TEMP:    prdata_next = {6'h00, tp_s2, 6'h00, tset_reg};
        OFS_TIME:    prdata_next = 32'(time_reg);
        OFS_ELAPSED: prdata_next = 32'(elapsed_reg);
        OFS_ENTRY:   prdata_next = {8'h00, entry_reg};
        OFS_VIEW:    prdata_next = {view_reg, 28'(view_slot)};
        default:     pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // One key event per keypad press; a pin press wins over an injected key.
  always_comb begin
    key_hit   = (kv_s2 && !kv_prev) || wr_key;
    key       = (kv_s2 && !kv_prev) ? kc_s2 : pwdata[4:0];
    digit     = key_hit && (key <= KEY_DIGIT_MAX);
    cur_slot  = {time_reg, tset_reg, temp_en_reg, pon_reg, poff_reg, ampl_reg};
    view_slot = slot_mem[view_reg];
  end

  // Entry machine. Function keys jump to their entry from any mode, so the
  // setup functions can be used in any order and combination.
  always_comb begin
    mode_next    = mode_reg;
    entry_next   = entry_reg;
    time_next    = time_reg;
    tset_next    = tset_reg;
    temp_en_next = temp_en_reg;
    pon_next     = pon_reg;
    poff_next    = poff_reg;
    view_next    = view_reg;
    ampl_next    = knob_pct(kn_s2);
    for (int i = 0; i < PRESET_SLOTS; i++) begin
      slot_next[i] = slot_mem[i];
    end
    if (wr_ctrl) begin
      temp_en_next = pwdata[CTRL_TEMP_EN_BIT];
    end
    if (key_hit) begin
      case (key)
        KEY_TIME:   mode_next = PSC_MODE_TIME;
        KEY_TEMP:   mode_next = PSC_MODE_TEMP;
        KEY_PULSE:  mode_next = PSC_MODE_PON;
        KEY_SAVE:   mode_next = PSC_MODE_SAVE;
        KEY_RECALL: mode_next = PSC_MODE_RECALL;
        default:    mode_next = mode_reg;
      endcase
      if (key >= KEY_TIME) begin
        entry_next = 24'h00_0000;
      end
    end
    if (mode_reg != PSC_MODE_MAIN && key_hit) begin
      if (digit) begin
        entry_next = {entry_reg[19:0], key[3:0]};
        if (mode_reg == PSC_MODE_RECALL) begin
          view_next = key[3:0];
        end
      end else if (key == KEY_CLEAR) begin
        entry_next = 24'h00_0000;
      end else if (key == KEY_ENTER) begin
        entry_next = 24'h00_0000;
        mode_next  = PSC_MODE_MAIN;
        case (mode_reg)
          PSC_MODE_TIME: begin
            // Digits arrive as HHMMSS; zero leaves the run untimed.
            time_next = TIME_W'(bcd2(entry_reg[23:16]) * 12'(SEC_PER_HOUR))
                      + TIME_W'(bcd2(entry_reg[15:8]) * 6'(SEC_PER_MIN))
                      + TIME_W'(bcd2(entry_reg[7:0]));
          end
          PSC_MODE_TEMP: begin
            tset_next    = bcd3(entry_reg[11:0]);
            temp_en_next = 1'b1;
          end
          PSC_MODE_PON: begin
            pon_next  = bcd2(entry_reg[7:0]);
            mode_next = PSC_MODE_POFF;
          end
          PSC_MODE_POFF: poff_next = bcd2(entry_reg[7:0]);
          PSC_MODE_SAVE: begin
            // An out-of-range ID leaves every slot untouched.
            if (entry_reg[3:0] <= PRESET_LAST) begin
              slot_next[entry_reg[3:0]] = cur_slot;
              view_next = entry_reg[3:0];
            end
          end
          PSC_MODE_RECALL: begin
            {time_next, tset_next, temp_en_next, pon_next, poff_next} =
              view_slot[SLOT_W-1:AMPL_W];
          end
          default: mode_next = PSC_MODE_MAIN;
        endcase
      end
    end
    lsave_next = (mode_next == PSC_MODE_SAVE);
    lrec_next  = (mode_next == PSC_MODE_RECALL);
  end

  // Presets are cleared only by reset and survive every run.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_reg    <= PSC_MODE_MAIN;
      entry_reg   <= 24'h00_0000;
      time_reg    <= '0;
      tset_reg    <= '0;
      temp_en_reg <= CTRL_TEMP_EN_RST;
      pon_reg     <= '0;
      poff_reg    <= '0;
      ampl_reg    <= '0;
      view_reg    <= 4'h0;
      lsave_reg   <= 1'b0;
      lrec_reg    <= 1'b0;
      for (int i = 0; i < PRESET_SLOTS; i++) begin
        slot_mem[i] <= '0;
      end
    end else begin
      mode_reg    <= mode_next;
      entry_reg   <= entry_next;
      time_reg    <= time_next;
      tset_reg    <= tset_next;
      temp_en_reg <= temp_en_next;
      pon_reg     <= pon_next;
      poff_reg    <= poff_next;
      ampl_reg    <= ampl_next;
      view_reg    <= view_next;
      lsave_reg   <= lsave_next;
      lrec_reg    <= lrec_next;
      for (int i = 0; i < PRESET_SLOTS; i++) begin
        slot_mem[i] <= slot_next[i];
      end
    end
  end

  // Run control. The thermal stop is a level, so the output comes back on
  // by itself once the sample cools below the setpoint.
  always_comb begin
    logic pulsing;
    logic expired;
    logic running;
    pulsing      = (pon_reg != '0) && (poff_reg != '0);
    expired      = (time_reg != '0) &&
                   (elapsed_reg >= ELAPSED_W'(time_reg * 4'(TENTHS_PER_SEC)));
    hot_next     = temp_en_reg && (tp_s2 >= tset_reg);
    src_next     = src_reg;
    elapsed_next = elapsed_reg;
    pcnt_next    = pcnt_reg;
    off_next     = off_reg;
    case (src_reg)
      PSC_SRC_IDLE: begin
        if (key_hit && key == KEY_START) begin
          src_next = PSC_SRC_KEY;
        end else if (ft_s2 && !ft_prev) begin
          src_next = PSC_SRC_FOOT;
        end
        elapsed_next = (src_next != PSC_SRC_IDLE) ? '0 : elapsed_reg;  // Held after a run.
        pcnt_next    = '0;
        off_next     = 1'b0;
      end
      PSC_SRC_KEY: begin
        // The footswitch has no say in a run started from the keypad.
        if ((key_hit && key == KEY_STOP) || expired) begin
          src_next = PSC_SRC_IDLE;
        end
      end
      PSC_SRC_FOOT: begin
        // The stop key has no say in a run started from the footswitch.
        if (!ft_s2 || expired) begin
          src_next = PSC_SRC_IDLE;
        end
      end
      default: src_next = PSC_SRC_IDLE;
    endcase
    running = (src_reg != PSC_SRC_IDLE) && (src_next != PSC_SRC_IDLE);
    if (!pulsing) begin
      off_next  = 1'b0;
      pcnt_next = '0;
    end else if (running && tick && !hot_reg) begin
      // Pulse phases hold still while the thermal limit has the output parked.
      if (pcnt_reg + 1'b1 >= (off_reg ? poff_reg : pon_reg)) begin
        pcnt_next = '0;
        off_next  = !off_reg;
      end else begin
        pcnt_next = pcnt_reg + 1'b1;
      end
    end
    if (running && tick && en_reg) begin
      elapsed_next = elapsed_reg + 1'b1;
    end
    en_next   = running && !hot_next && !(pulsing && off_next);
    wstb_next = running && pulsing && off_next &&
                (poff_reg > STANDBY_WARN_TENTHS);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_reg     <= PSC_SRC_IDLE;
      elapsed_reg <= '0;
      pcnt_reg    <= '0;
      off_reg     <= 1'b0;
      hot_reg     <= 1'b0;
      en_reg      <= 1'b0;
      wstb_reg    <= 1'b0;
    end else begin
      src_reg     <= src_next;
      elapsed_reg <= elapsed_next;
      pcnt_reg    <= pcnt_next;
      off_reg     <= off_next;
      hot_reg     <= hot_next;
      en_reg      <= en_next;
      wstb_reg    <= wstb_next;
    end
  end

  // Every output is a flip-flop.
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign energize     = en_reg;
  assign led_temp     = hot_reg;
  assign warn_touch   = hot_reg;
  assign led_pulse    = off_reg;
  assign led_save     = lsave_reg;
  assign led_recall   = lrec_reg;
  assign warn_standby = wstb_reg;

endmodule

`default_nettype wire

/* File: tb/psc_properties.sv */
// Port checker for the controller: lamp, output and bus answer relations.
// Assumes a bind onto psc_controller; it sees that module's ports only.
`default_nettype none

module psc_properties #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic energize,
  input wire logic led_temp,
  input wire logic led_pulse,
  input wire logic led_save,
  input wire logic led_recall,
  input wire logic warn_touch,
  input wire logic warn_standby
);
  timeunit 1ns;
  timeprecision 1ps;

  // One clock domain, so every check shares it and pauses in reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // The drive must be off whenever a lamp says the probe is idle.
  property p_temp_off; led_temp |-> !energize; endproperty
  a_temp_off: assert property (p_temp_off)
    else $error("drive on during over-temp");
  property p_touch; led_temp == warn_touch; endproperty
  a_touch: assert property (p_touch)
    else $error("touch warning differs from thermal lamp");
  property p_pulse_off; led_pulse |-> !energize; endproperty
  a_pulse_off: assert property (p_pulse_off)
    else $error("drive on in pulse off phase");
  property p_standby; warn_standby |-> led_pulse; endproperty
  a_standby: assert property (p_standby)
    else $error("standby warning outside off phase");
  property p_lamps; !(led_save && led_recall); endproperty
  a_lamps: assert property (p_lamps)
    else $error("save and recall lamps lit together");

  // Bus answers in the first access cycle, for one cycle only.
  property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not in first access cycle");
  property p_one; $rose(pready) |-> $past(psel); endproperty
  a_one: assert property (p_one)
    else $error("ready without a selected transfer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error flag without ready");
endmodule

bind psc_controller psc_properties #(.TICK_CYCLES(TICK_CYCLES)) u_psc_properties (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .energize(energize), .led_temp(led_temp),
  .led_pulse(led_pulse), .led_save(led_save), .led_recall(led_recall),
  .warn_touch(warn_touch), .warn_standby(warn_standby)
);

`default_nettype wire

/* File: tb/psc_operator.sv */
// Stand-in for operator and sensor: keypad strobe, footswitch, temperature.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`default_nettype none

module psc_operator (
  input  wire logic                  mclk,
  output logic                       key_valid,
  output logic [4:0]                 key_code,
  output logic                       footswitch,
  output logic [psc_pkg::TEMP_W-1:0] temp_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;

  // Idle pins at time zero; the code lines carry junk while no key is down.
  initial begin
    key_valid  = 1'b0;
    key_code   = 5'h1f;
    footswitch = 1'b0;
    temp_sense = TEMP_W'(20);
  end

  // One press: code settles before the strobe so the sync flops see it whole.
  task automatic press(input logic [4:0] k);
    @(posedge mclk);
    key_code <= k;
    repeat (3) @(posedge mclk);
    key_valid <= 1'b1;
    repeat (4) @(posedge mclk);
    key_valid <= 1'b0;
    key_code  <= ~k;
    repeat (6) @(posedge mclk);
  endtask

  // Footswitch level (high is pressed) and sample temperature.
  task automatic pins(input logic f, input logic [TEMP_W-1:0] t);
    @(posedge mclk);
    footswitch <= f;
    temp_sense <= t;
  endtask
endmodule

`default_nettype wire

/* File: tb/psc_controller_bench.sv */
// Self-checking bench: registers over APB, keypad walks, key and foot runs,
// pulse, thermal limit and presets. Assumes psc_operator drives the panel.
`default_nettype none

module psc_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;

  logic              mclk;
  logic              rst_n;
  logic [7:0]        paddr;
  logic              psel, penable, pwrite, pready, pslverr, err;
  logic [31:0]       pwdata, prdata, rdata;
  logic              key_valid, footswitch;
  logic [4:0]        key_code;
  logic [TEMP_W-1:0] temp_sense;
  logic [KNOB_W-1:0] ampl_knob;
  logic              energize, led_temp, led_pulse, led_save, led_recall;
  logic              warn_touch, warn_standby;
  int                num_errors = 0, checked = 0;

  // A ten-cycle tick keeps runs short.
  psc_controller #(.TICK_CYCLES(10)) u_psc_controller (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_valid(key_valid), .key_code(key_code),
    .footswitch(footswitch), .temp_sense(temp_sense), .ampl_knob(ampl_knob),
    .energize(energize), .led_temp(led_temp), .led_pulse(led_pulse),
    .led_save(led_save), .led_recall(led_recall), .warn_touch(warn_touch),
    .warn_standby(warn_standby)
  );
  psc_operator u_psc_operator (
    .mclk(mclk), .key_valid(key_valid), .key_code(key_code),
    .footswitch(footswitch), .temp_sense(temp_sense)
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // One transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  // Up to eight keys packed five bits each, first key highest.
  task automatic keys(input int n, input logic [39:0] s);
    for (int i = n - 1; i >= 0; i--) u_psc_operator.press(s[5*i +: 5]);
  endtask

  task automatic wait_en(input logic v, input int lim);
    for (int i = 0; i < lim && energize !== v; i++) @(posedge mclk);
    chk(32'(energize), 32'(v));
    if (energize !== v) give_verdict();
  endtask

  // Main sequence; settings carry over between steps.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ampl_knob = 8'hff;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_STATUS, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    rd(OFS_KEY, 32'hffffffff, 32'h0);
    rd(OFS_PULSE, 32'h7f000000, 32'h64000000);
    ampl_knob <= 8'h80;
    repeat (3) @(posedge mclk);
    rd(OFS_PULSE, 32'h7f000000, 32'h32000000);
    // Untimed key run ignores the footswitch and stops only on the key.
    u_psc_operator.press(KEY_START);
    wait_en(1'b1, 5);
    u_psc_operator.pins(1'b1, TEMP_W'(20));
    u_psc_operator.pins(1'b0, TEMP_W'(20));
    repeat (400) @(posedge mclk);
    rd(OFS_STATUS, 32'h130, 32'h110);
    u_psc_operator.press(KEY_STOP);
    wait_en(1'b0, 2);
    // Foot run ignores the stop key and ends on release.
    u_psc_operator.pins(1'b1, TEMP_W'(20));
    wait_en(1'b1, 8);
    u_psc_operator.press(KEY_STOP);
    rd(OFS_STATUS, 32'h130, 32'h130);
    u_psc_operator.pins(1'b0, TEMP_W'(20));
    wait_en(1'b0, 8);
    // Thermal limit: entry, stop at setpoint, resume below it.
    u_psc_operator.press(KEY_TEMP);
    rd(OFS_STATUS, 32'h7, 32'h3);
    rd(OFS_TEMP, 32'h3ff0000, 32'h140000);
    keys(4, {5'h0, 5'h3, 5'h5, KEY_ENTER});
    rd(OFS_TEMP, 32'h3ff, 32'h23);
    rd(OFS_CTRL, 32'h1, 32'h1);
    u_psc_operator.press(KEY_START);
    u_psc_operator.pins(1'b0, TEMP_W'(35));
    wait_en(1'b0, 20);
    chk(32'({led_temp, warn_touch}), 32'h3);
    u_psc_operator.pins(1'b0, TEMP_W'(34));
    wait_en(1'b1, 20);
    u_psc_operator.press(KEY_STOP);
    apb(1'b1, OFS_CTRL, 32'h0);
    // Time entry, then a clear in mid-entry, then a short timed run.
    keys(8, {KEY_TIME, 5'h0, 5'h5, 5'h3, 5'h0, 5'h2, 5'h5, KEY_ENTER});
    rd(OFS_TIME, 32'hffffffff, 32'h4d71);
    rd(OFS_STATUS, 32'h7, 32'h0);
    keys(3, {KEY_TIME, 5'h1, 5'h2});
    rd(OFS_ENTRY, 32'hff, 32'h12);
    u_psc_operator.press(KEY_CLEAR);
    rd(OFS_ENTRY, 32'hff, 32'h0);
    keys(3, {5'h3, KEY_ENTER, KEY_START});
    wait_en(1'b0, 600);
    rd(OFS_ELAPSED, 32'hffffffff, 32'd30);
    // Pulse 1.0 on, 2.5 off; the long off phase warns of standby.
    keys(4, {KEY_PULSE, 5'h1, 5'h0, KEY_ENTER});
    rd(OFS_STATUS, 32'h7, 32'h6);
    keys(3, {5'h2, 5'h5, KEY_ENTER});
    rd(OFS_PULSE, 32'h7f007f, 32'h19000a);
    u_psc_operator.press(KEY_START);
    for (int i = 0; i < 200 && led_pulse !== 1'b1; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    chk(32'({led_pulse, warn_standby, energize}), 32'h6);
    if (led_pulse !== 1'b1) give_verdict();
    apb(1'b1, OFS_KEY, 32'(KEY_STOP));
    repeat (10) @(posedge mclk);
    rd(OFS_STATUS, 32'h4130, 32'h0);
    // Save to slot 7, spoil the pulse setting, recall it.
    u_psc_operator.press(KEY_SAVE);
    chk(32'(led_save), 32'h1);
    keys(2, {5'h7, KEY_ENTER});
    chk(32'(led_save), 32'h0);
    rd(OFS_VIEW, 32'hf01fffff, 32'h70028cb2);
    keys(5, {KEY_PULSE, 5'h0, KEY_ENTER, 5'h0, KEY_ENTER});
    rd(OFS_PULSE, 32'h7f007f, 32'h0);
    keys(2, {KEY_RECALL, 5'h7});
    chk(32'(led_recall), 32'h1);
    rd(OFS_VIEW, 32'hf0000000, 32'h70000000);
    u_psc_operator.press(KEY_ENTER);
    rd(OFS_PULSE, 32'h7f007f, 32'h19000a);
    give_verdict();
  end
endmodule

`default_nettype wire
